// file: src/ofs_pkg.sv
// shared constants for the optical front end system register group
package ofs_pkg;
    // register offsets
    localparam logic [7:0] OFS_ADDR_TARGET = 8'h09;
    localparam logic [7:0] OFS_ADDR_RATIO = 8'h0A;
    localparam logic [7:0] OFS_ADDR_KEY = 8'h0D;
    localparam logic [7:0] OFS_ADDR_SWRST = 8'h0F;
    localparam logic [7:0] OFS_ADDR_MODE = 8'h10;
    localparam logic [7:0] OFS_ADDR_CFG = 8'h11;
    // reset values
    localparam logic [6:0] OFS_TARGET_RST = 7'h64;
    localparam logic [15:0] OFS_KEY_RST = 16'h0000;
    localparam logic [1:0] OFS_MODE_RST = 2'h0;
    localparam logic [15:0] OFS_CFG_RST = 16'h1000;
    // unlock byte and address-change keys
    localparam logic [7:0] OFS_UNLOCK_BYTE = 8'hAD;
    localparam logic [15:0] OFS_KEY_ALWAYS = 16'h04AD;
    localparam logic [15:0] OFS_KEY_INT = 16'h44AD;
    localparam logic [15:0] OFS_KEY_STRAP = 16'h84AD;
    localparam logic [15:0] OFS_KEY_BOTH = 16'hC4AD;
    // field positions in the configuration register
    localparam int OFS_CFG_READBACK_BIT = 13;
    localparam int OFS_CFG_GUARD_BIT = 12;
    localparam int OFS_CFG_SLOTB_LSB = 6;
    localparam int OFS_CFG_SLOTA_LSB = 2;
    localparam logic [15:0] OFS_CFG_WMASK = 16'h31DC;
    // calibration: two slow periods of the slow clock
    localparam logic [1:0] OFS_CAL_SLOW_EDGES = 2'h2;
    typedef enum logic [1:0] {
        OFS_MODE_STANDBY = 2'b00,
        OFS_MODE_PROGRAM = 2'b01,
        OFS_MODE_NORMAL = 2'b10,
        OFS_MODE_RESVD = 2'b11
    } ofs_mode_e;
    typedef enum logic [2:0] {
        OFS_FMT_NONE = 3'b000,
        OFS_FMT_SUM16 = 3'b001,
        OFS_FMT_SUM32 = 3'b010,
        OFS_FMT_BG16 = 3'b011,
        OFS_FMT_WIDE4 = 3'b100,
        OFS_FMT_RES5 = 3'b101,
        OFS_FMT_EXT4 = 3'b110,
        OFS_FMT_RES7 = 3'b111
    } ofs_fmt_e;
endpackage

// file: src/ofs_clock_cal.sv
// counts fast clock edges across two slow clock periods
`timescale 1ns/10ps
module ofs_clock_cal (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic softReset,
    // control
    input wire logic calEnable,
    input wire logic slowClkPin,
    // result
    output logic [11:0] fastClockCount
);
    localparam logic [1:0] OFS_CAL_SLOW_EDGES_C = ofs_pkg::OFS_CAL_SLOW_EDGES;
    logic [2:0] slowSync_q;
    logic [1:0] edgeCnt_q;
    logic [11:0] runCnt_q;
    logic [11:0] fastClockCount_q;
    logic slowRise;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            slowSync_q <= 3'h0;
        end else begin
            slowSync_q <= {slowSync_q[1:0], slowClkPin};
        end
    end
    // edge detector reads only the second and third stages
    assign slowRise = slowSync_q[1] & ~slowSync_q[2];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            edgeCnt_q <= 2'h0;
            runCnt_q <= 12'h000;
            fastClockCount_q <= 12'h000;
        end else if (softReset) begin
            edgeCnt_q <= 2'h0;
            runCnt_q <= 12'h000;
            fastClockCount_q <= 12'h000;
        end else if (!calEnable) begin
            edgeCnt_q <= 2'h0;
            runCnt_q <= 12'h000;
        end else if (slowRise) begin
            if (edgeCnt_q == OFS_CAL_SLOW_EDGES_C) begin
                fastClockCount_q <= runCnt_q;
                runCnt_q <= 12'h001;
                edgeCnt_q <= 2'h1;
            end else begin
                edgeCnt_q <= edgeCnt_q + 2'h1;
                runCnt_q <= (edgeCnt_q == 2'h0) ? 12'h001 : runCnt_q + 12'h001;
            end
        end else if (edgeCnt_q != 2'h0) begin
            runCnt_q <= runCnt_q + 12'h001;
        end
    end
    assign fastClockCount = fastClockCount_q;
endmodule

// file: src/ofs_fifo_format.sv
// decodes the per-slot queue format into a word count and width
`timescale 1ns/10ps
module ofs_fifo_format (
    // selection
    input wire logic [2:0] queueFormat,
    input wire logic integrationMode,
    // decoded result
    output logic [3:0] wordsPerSample,
    output logic wideWords,
    output logic formatValid
);
    always_comb begin
        wordsPerSample = 4'h0;
        wideWords = 1'b0;
        formatValid = 1'b1;
        unique case (ofs_pkg::ofs_fmt_e'(queueFormat))
            ofs_pkg::OFS_FMT_NONE: begin
                formatValid = 1'b1;
            end
            ofs_pkg::OFS_FMT_SUM16: begin
                wordsPerSample = 4'h1;
            end
            ofs_pkg::OFS_FMT_SUM32: begin
                wordsPerSample = 4'h2;
                wideWords = 1'b1;
            end
            ofs_pkg::OFS_FMT_BG16: begin
                // only meaningful in digital integration mode
                wordsPerSample = integrationMode ? 4'h2 : 4'h0;
                formatValid = integrationMode;
            end
            ofs_pkg::OFS_FMT_WIDE4: begin
                wordsPerSample = 4'h4;
                wideWords = integrationMode;
            end
            ofs_pkg::OFS_FMT_EXT4: begin
                wordsPerSample = integrationMode ? 4'h0 : 4'h8;
                wideWords = ~integrationMode;
                formatValid = ~integrationMode;
            end
            default: begin
                formatValid = 1'b0;
            end
        endcase
    end
endmodule

// file: src/ofs_system_regs.sv
// system control register group: address change, calibration, reset, mode, queue config
`timescale 1ns/10ps
module ofs_system_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port from the serial interface engine
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic regAck,
    // gating pins, asynchronous to core_clk
    input wire logic interruptPin,
    input wire logic gating_strap_pin,
    // slow reference clock pin, asynchronous
    input wire logic slowClkPin,
    // calibration enable from the sampling control group
    input wire logic fastClockCalibrationEnable,
    // datapath status and requests
    input wire logic integrationMode,
    input wire logic [2:0] slotAAveraging,
    input wire logic [2:0] slotBAveraging,
    input wire logic slotBSampleReady,
    input wire logic queueFull,
    // controls to the rest of the device
    output logic [6:0] busTargetId,
    output logic softResetPulse,
    output logic [1:0] operatingMode,
    output logic standbyActive,
    output logic programActive,
    output logic normalActive,
    output logic extendedReadbackAverage,
    output logic queueOverflowGuard,
    output logic [2:0] secondSlotQueueFormat,
    output logic [2:0] firstSlotQueueFormat,
    output logic slotBQueueWrite,
    output logic queueDropOldest,
    output logic [3:0] slotBWordsPerSample,
    output logic slotBWideWords,
    output logic slotBFormatError
);
    logic [1:0] intSync_q;
    logic [1:0] strapSync_q;
    logic [6:0] targetId_q;
    logic [15:0] changeKey_q;
    logic softReset_q;
    logic [1:0] mode_q;
    logic [15:0] cfg_q;
    logic [15:0] regRdata_q;
    logic regAck_q;
    logic [11:0] fastClockCount;
    logic changeAllowed;
    logic unlockOk;
    logic softResetHit;
    logic slotBAllowed;
    logic [3:0] slotBWords;
    logic slotBWide;
    logic slotBValid;

    // gating pins pass two flops before any decision reads them
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            intSync_q <= 2'h0;
            strapSync_q <= 2'h0;
        end else begin
            intSync_q <= {intSync_q[0], interruptPin};
            strapSync_q <= {strapSync_q[0], gating_strap_pin};
        end
    end

    always_comb begin
        unique case (changeKey_q)
            ofs_pkg::OFS_KEY_ALWAYS: changeAllowed = 1'b1;
            ofs_pkg::OFS_KEY_INT: changeAllowed = intSync_q[1];
            ofs_pkg::OFS_KEY_STRAP: changeAllowed = strapSync_q[1];
            ofs_pkg::OFS_KEY_BOTH: changeAllowed = intSync_q[1] & strapSync_q[1];
            default: changeAllowed = 1'b0;
        endcase
    end
    assign unlockOk = regWdata[15:8] == ofs_pkg::OFS_UNLOCK_BYTE;
    assign softResetHit = regWrite && regAddr == ofs_pkg::OFS_ADDR_SWRST && regWdata[0];

    // software reset: one cycle pulse, bit reads back low afterwards
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            softReset_q <= 1'b0;
        end else begin
            softReset_q <= softResetHit;
        end
    end

    // target address, reset to its power-up value by the software reset too
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            targetId_q <= ofs_pkg::OFS_TARGET_RST;
        end else if (softReset_q) begin
            targetId_q <= ofs_pkg::OFS_TARGET_RST;
        end else if (regWrite && regAddr == ofs_pkg::OFS_ADDR_TARGET && unlockOk && changeAllowed) begin
            targetId_q <= regWdata[7:1];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            changeKey_q <= ofs_pkg::OFS_KEY_RST;
        end else if (softReset_q) begin
            changeKey_q <= ofs_pkg::OFS_KEY_RST;
        end else if (regWrite && regAddr == ofs_pkg::OFS_ADDR_KEY) begin
            changeKey_q <= regWdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= ofs_pkg::OFS_MODE_RST;
        end else if (softReset_q) begin
            mode_q <= ofs_pkg::OFS_MODE_RST;
        end else if (regWrite && regAddr == ofs_pkg::OFS_ADDR_MODE) begin
            mode_q <= regWdata[1:0];
        end
    end

    always_comb begin
        standbyActive = 1'b0;
        programActive = 1'b0;
        normalActive = 1'b0;
        unique case (ofs_pkg::ofs_mode_e'(mode_q))
            ofs_pkg::OFS_MODE_STANDBY: standbyActive = 1'b1;
            ofs_pkg::OFS_MODE_PROGRAM: programActive = 1'b1;
            ofs_pkg::OFS_MODE_NORMAL: normalActive = 1'b1;
            // reserved code holds the device in standby as the safe choice
            default: standbyActive = 1'b1;
        endcase
    end

    // reserved bits are masked so they always read zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= ofs_pkg::OFS_CFG_RST;
        end else if (softReset_q) begin
            cfg_q <= ofs_pkg::OFS_CFG_RST;
        end else if (regWrite && regAddr == ofs_pkg::OFS_ADDR_CFG) begin
            cfg_q <= regWdata & ofs_pkg::OFS_CFG_WMASK;
        end
    end

    assign extendedReadbackAverage = cfg_q[ofs_pkg::OFS_CFG_READBACK_BIT];
    assign queueOverflowGuard = cfg_q[ofs_pkg::OFS_CFG_GUARD_BIT];
    assign secondSlotQueueFormat = cfg_q[ofs_pkg::OFS_CFG_SLOTB_LSB +: 3];
    assign firstSlotQueueFormat = cfg_q[ofs_pkg::OFS_CFG_SLOTA_LSB +: 3];

    ofs_fifo_format slotBDecode (
        .queueFormat(secondSlotQueueFormat),
        .integrationMode(integrationMode),
        .wordsPerSample(slotBWords),
        .wideWords(slotBWide),
        .formatValid(slotBValid)
    );

    ofs_clock_cal clockCal (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .softReset(softReset_q),
        .calEnable(fastClockCalibrationEnable),
        .slowClkPin(slowClkPin),
        .fastClockCount(fastClockCount)
    );

    // slot B storage needs matching averaging or an idle slot A queue
    assign slotBAllowed = (slotAAveraging == slotBAveraging) || (firstSlotQueueFormat == 3'h0);

    // queue write decision; the guard stalls writes while full, else oldest is dropped
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            slotBQueueWrite <= 1'b0;
            queueDropOldest <= 1'b0;
            slotBWordsPerSample <= 4'h0;
            slotBWideWords <= 1'b0;
            slotBFormatError <= 1'b0;
        end else begin
            slotBWordsPerSample <= slotBWords;
            slotBWideWords <= slotBWide;
            slotBFormatError <= ~slotBValid;
            if (slotBSampleReady && slotBValid && slotBWords != 4'h0 && slotBAllowed) begin
                slotBQueueWrite <= ~(queueOverflowGuard && queueFull);
                queueDropOldest <= ~queueOverflowGuard && queueFull;
            end else begin
                slotBQueueWrite <= 1'b0;
                queueDropOldest <= 1'b0;
            end
        end
    end

    // read data registered; unmapped and write-only fields read zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata_q <= 16'h0000;
        end else if (regRead) begin
            unique case (regAddr)
                ofs_pkg::OFS_ADDR_TARGET: regRdata_q <= {8'h00, targetId_q, 1'b0};
                ofs_pkg::OFS_ADDR_RATIO: regRdata_q <= {4'h0, fastClockCount};
                ofs_pkg::OFS_ADDR_KEY: regRdata_q <= changeKey_q;
                ofs_pkg::OFS_ADDR_SWRST: regRdata_q <= {15'h0000, softReset_q};
                ofs_pkg::OFS_ADDR_MODE: regRdata_q <= {14'h0000, mode_q};
                ofs_pkg::OFS_ADDR_CFG: regRdata_q <= cfg_q;
                default: regRdata_q <= 16'h0000;
            endcase
        end
    end

    // acknowledge every access except the write that fires the software reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regAck_q <= 1'b0;
        end else begin
            regAck_q <= (regWrite || regRead) && !softResetHit;
        end
    end

    assign regRdata = regRdata_q;
    assign regAck = regAck_q;
    assign busTargetId = targetId_q;
    assign softResetPulse = softReset_q;
    assign operatingMode = mode_q;
endmodule

// file: dv/ofs_props.sv
// port checker for the system register group
`timescale 1ns/10ps
module ofs_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regAck,
    // pins and datapath
    input wire logic interruptPin,
    input wire logic gating_strap_pin,
    input wire logic integrationMode,
    input wire logic [2:0] slotAAveraging,
    input wire logic [2:0] slotBAveraging,
    input wire logic slotBSampleReady,
    input wire logic queueFull,
    // controls
    input wire logic [6:0] busTargetId,
    input wire logic softResetPulse,
    input wire logic [1:0] operatingMode,
    input wire logic standbyActive,
    input wire logic normalActive,
    input wire logic extendedReadbackAverage,
    input wire logic queueOverflowGuard,
    input wire logic [2:0] secondSlotQueueFormat,
    input wire logic [2:0] firstSlotQueueFormat,
    input wire logic slotBQueueWrite,
    input wire logic queueDropOldest,
    input wire logic slotBFormatError
);
    logic [15:0] keyQ;
    logic [5:0] pinsQ;
    logic wrTgt, wrRst, steady, permit, fmtOk, wantWr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // key shadow and pin history, so the gate can only be judged once the pins have settled
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            keyQ <= 16'h0000;
            pinsQ <= 6'h00;
        end else begin
            pinsQ <= {pinsQ[3:0], interruptPin, gating_strap_pin};
            if (softResetPulse) begin
                keyQ <= 16'h0000;
            end else if (regWrite && regAddr == 8'h0D) begin
                keyQ <= regWdata;
            end
        end
    end
    assign wrTgt = regWrite && regAddr == 8'h09 && !softResetPulse;
    assign wrRst = regWrite && regAddr == 8'h0F && regWdata[0];
    assign steady = pinsQ == {3{interruptPin, gating_strap_pin}};
    assign permit = keyQ[13:0] == 14'h04AD && &(~keyQ[15:14] | {gating_strap_pin, interruptPin});
    assign fmtOk = secondSlotQueueFormat inside {3'h1, 3'h2, 3'h4} || secondSlotQueueFormat == (integrationMode ? 3'h3 : 3'h6);
    assign wantWr = fmtOk && (slotAAveraging == slotBAveraging || firstSlotQueueFormat == 3'h0) && !(queueOverflowGuard && queueFull);

    a_req_acked: assert property ((regWrite || regRead) && !wrRst && !softResetPulse |=> regAck)
        else $error("request without acknowledge");
    a_reset_pulse: assert property (wrRst |=> softResetPulse && !regAck)
        else $error("reset write mishandled");
    a_reset_restores: assert property (softResetPulse |=> busTargetId == 7'h64 && operatingMode == 2'h0 && !softResetPulse)
        else $error("software reset incomplete");
    a_mode_written: assert property (regWrite && regAddr == 8'h10 && !softResetPulse |=> operatingMode == $past(regWdata[1:0]))
        else $error("mode not updated");
    a_mode_decode: assert property (normalActive == (operatingMode == 2'h2) && standbyActive == !(operatingMode inside {2'h1, 2'h2}))
        else $error("mode decode wrong");
    a_target_gated: assert property (wrTgt && regWdata[15:8] == 8'hAD && steady |=> busTargetId == ($past(permit) ? $past(regWdata[7:1]) : $past(busTargetId)))
        else $error("target id gate wrong");
    a_target_locked: assert property (wrTgt && regWdata[15:8] != 8'hAD |=> $stable(busTargetId))
        else $error("target id changed without unlock");
    a_cfg_fields: assert property (regWrite && regAddr == 8'h11 && !softResetPulse |=> extendedReadbackAverage == $past(regWdata[13]) && queueOverflowGuard == $past(regWdata[12]))
        else $error("config fields not updated");
    a_queue_write: assert property (slotBSampleReady |=> slotBQueueWrite == $past(wantWr) && queueDropOldest == ($past(wantWr) && !$past(queueOverflowGuard) && $past(queueFull)))
        else $error("queue decision wrong");
    a_format_error: assert property (##1 slotBFormatError == !($past(fmtOk) || $past(secondSlotQueueFormat) == 3'h0))
        else $error("format error flag wrong");
    c_soft_reset: cover property (softResetPulse);
    c_target_move: cover property (wrTgt && permit && steady);
    c_drop_oldest: cover property (queueDropOldest);
endmodule

// file: dv/ofs_host_model.sv
// host model for the register port of the system register group
`timescale 1ns/10ps
module ofs_host_model (
    // clock
    input wire logic core_clk,
    // register port
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    input wire logic regAck
);
    initial begin
        {regWrite, regRead, regAddr, regWdata} = 26'h0000000;
    end
    // no wait on the acknowledge: a reset write is never answered, so the host moves on
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                          output logic ok, output logic [15:0] q);
        @(posedge core_clk);
        {regWrite, regRead, regAddr, regWdata} <= {wr, !wr, a, d};
        @(posedge core_clk);
        {regWrite, regRead, regWdata} <= {2'h0, ~d};
        #1;
        ok = regAck;
        q = regRdata;
    endtask
endmodule

// file: dv/optical_frontend_system_regs_tb.sv
// self-checking bench for the system register group
`timescale 1ns/10ps
module optical_frontend_system_regs_tb;
    localparam int SlowHalf = 156;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrite, regRead, regAck, interruptPin, gating_strap_pin, fastClockCalibrationEnable;
    logic slowClkPin = 1'b0;
    logic integrationMode, slotBSampleReady, queueFull, softResetPulse, standbyActive, programActive;
    logic normalActive, extendedReadbackAverage, queueOverflowGuard, slotBQueueWrite, queueDropOldest;
    logic slotBWideWords, slotBFormatError, ack;
    logic [1:0] operatingMode;
    logic [2:0] slotAAveraging, slotBAveraging, secondSlotQueueFormat, firstSlotQueueFormat;
    logic [3:0] slotBWordsPerSample;
    logic [6:0] busTargetId, id, tgtExp;
    logic [7:0] regAddr;
    logic [15:0] regWdata, regRdata, rd, d, r, key;
    logic [31:0] wt;
    int err_count = 0;
    int num_checks = 0;
    int seed = 75687;
    int cycles = 0;
    int slowCnt = 0;

    ofs_system_regs u_ofs_system_regs (.core_clk, .rst_b, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
        .regAck, .interruptPin, .gating_strap_pin, .slowClkPin, .fastClockCalibrationEnable, .integrationMode,
        .slotAAveraging, .slotBAveraging, .slotBSampleReady, .queueFull, .busTargetId, .softResetPulse,
        .operatingMode, .standbyActive, .programActive, .normalActive, .extendedReadbackAverage,
        .queueOverflowGuard, .secondSlotQueueFormat, .firstSlotQueueFormat, .slotBQueueWrite, .queueDropOldest,
        .slotBWordsPerSample, .slotBWideWords, .slotBFormatError);
    ofs_host_model u_ofs_host_model (.core_clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regAck);

    always #50 core_clk = ~core_clk;
    // the reference pin free runs, so two of its periods span 4 * SlowHalf core cycles
    always @(posedge core_clk) begin
        slowCnt <= (slowCnt == SlowHalf - 1) ? 0 : slowCnt + 1;
        if (slowCnt == SlowHalf - 1) begin
            slowClkPin <= ~slowClkPin;
        end
        // whole run needs about 2150 cycles
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        u_ofs_host_model.access(1'b1, a, v, ack, rd);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [15:0] exp);
        u_ofs_host_model.access(1'b0, a, 16'h0000, ack, rd);
        check(what, rd, exp);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // s holds integration mode [4], queue full [3], slot averages [2:0] and [7:5]
    function automatic logic [2:0] expQ(input logic [15:0] c, input logic [15:0] s);
        logic ok;
        logic go;
        ok = c[8:6] inside {3'h0, 3'h1, 3'h2, 3'h4} || c[8:6] == (s[4] ? 3'h3 : 3'h6);
        go = ok && c[8:6] != 3'h0 && (s[2:0] == s[7:5] || c[4:2] == 3'h0) && !(c[12] && s[3]);
        return {!ok, go, go && !c[12] && s[3]};
    endfunction

    initial begin
        {interruptPin, gating_strap_pin, fastClockCalibrationEnable, integrationMode} = 4'h0;
        {slotBSampleReady, queueFull, slotAAveraging, slotBAveraging} = 8'h00;
        tgtExp = 7'h64;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        rdc("target", 8'h09, 16'h00C8);
        rdc("ratio", 8'h0A, 16'h0000);
        rdc("key", 8'h0D, 16'h0000);
        rdc("mode", 8'h10, 16'h0000);
        rdc("config", 8'h11, 16'h1000);
        rdc("unmapped", 8'h20, 16'h0000);
        $display("test reset values done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h10, 16'(m));
            d = 16'({2'(m), m == 0 || m == 3, m == 1, m == 2});
            check("mode outputs", 16'({operatingMode, standbyActive, programActive, normalActive}), d);
        end
        $display("test modes done");
        for (int k = 0; k < 20; k++) begin
            key = (k < 4) ? 16'h0000 : {2'(k / 4 - 1), 14'h04AD};
            @(posedge core_clk);
            {interruptPin, gating_strap_pin} <= 2'(k);
            repeat (4) @(posedge core_clk);
            wr(8'h0D, key);
            rdc("key", 8'h0D, key);
            id = 7'($random(seed));
            if (key[13:0] == 14'h04AD && &(~key[15:14] | {k[0], k[1]})) tgtExp = id;
            wr(8'h09, {8'hAD, id, 1'b0});
            check("target id", 16'(busTargetId), 16'(tgtExp));
            wr(8'h09, {8'h00, ~id, 1'b0});
            check("locked target id", 16'(busTargetId), 16'(tgtExp));
        end
        $display("test address change done");
        for (int i = 0; i < 40; i++) begin
            d = 16'($random(seed));
            if (i < 8) d[8:6] = 3'(i);
            wr(8'h11, d);
            rdc("config", 8'h11, d & 16'h31DC);
            r = 16'($random(seed));
            if (i[0]) r[7:5] = r[2:0];
            // datapath inputs change on the edge, like every other stimulus
            @(posedge core_clk);
            {integrationMode, queueFull, slotAAveraging} <= r[4:0];
            slotBAveraging <= r[7:5];
            slotBSampleReady <= 1'b1;
            @(posedge core_clk);
            slotBSampleReady <= 1'b0;
            #1;
            check("queue", 16'({slotBFormatError, slotBQueueWrite, queueDropOldest}), 16'(expQ(d, r)));
            wt = (r[4] ? 32'h00042210 : 32'h08040210) >> (4 * d[8:6]);
            check("words", 16'(slotBWordsPerSample), 16'(wt[3:0]));
            check("wide", 16'(slotBWideWords), 16'(d[8:6] == 3'h2 || d[8:6] == (r[4] ? 3'h4 : 3'h6)));
            check("cfg outputs", 16'({extendedReadbackAverage, queueOverflowGuard, secondSlotQueueFormat,
                firstSlotQueueFormat}), 16'({d[13], d[12], d[8:6], d[4:2]}));
        end
        $display("test queue format done");
        @(posedge core_clk);
        fastClockCalibrationEnable <= 1'b1;
        repeat (1600) @(posedge core_clk);
        u_ofs_host_model.access(1'b0, 8'h0A, 16'h0000, ack, rd);
        check("ratio in band", 16'(rd >= 4 * SlowHalf - 1 && rd <= 4 * SlowHalf + 1), 16'h0001);
        @(posedge core_clk);
        fastClockCalibrationEnable <= 1'b0;
        wr(8'h0F, 16'h0000);
        check("plain write ack", 16'(ack), 16'h0001);
        wr(8'h0F, 16'h0001);
        check("reset write ack", 16'(ack), 16'h0000);
        repeat (2) @(posedge core_clk);
        rdc("reset bit", 8'h0F, 16'h0000);
        rdc("ratio", 8'h0A, 16'h0000);
        rdc("mode", 8'h10, 16'h0000);
        rdc("config", 8'h11, 16'h1000);
        check("target id", 16'(busTargetId), 16'h0064);
        $display("test calibration and soft reset done");
        stop_test();
    end
endmodule

bind ofs_system_regs ofs_props u_ofs_props (.core_clk, .rst_b, .regWrite, .regRead, .regAddr, .regWdata, .regAck,
    .interruptPin, .gating_strap_pin, .integrationMode, .slotAAveraging, .slotBAveraging, .slotBSampleReady,
    .queueFull, .busTargetId, .softResetPulse, .operatingMode, .standbyActive, .normalActive,
    .extendedReadbackAverage, .queueOverflowGuard, .secondSlotQueueFormat, .firstSlotQueueFormat,
    .slotBQueueWrite, .queueDropOldest, .slotBFormatError);
